// ===== hdl/seq_pkg.sv
// Purpose: Shared constants, types and register map of the sequencer.
// Assumes: One clock, pclk at 25 MHz, asynchronous active-low reset.
// Notes: Contract
package seq_pkg;
  localparam int WORD_W = 24;
  localparam int ADDR_W = 13;
  localparam int COUNT_W = 5;
  localparam logic [COUNT_W-1:0] ITERATION_START = 5'h17;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 5'h00;
  localparam logic [7:0] CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] OPERAND_OFFSET = 8'h04;
  localparam logic [7:0] ACCUMULATOR_OFFSET = 8'h08;
  localparam logic [7:0] EXTENSION_OFFSET = 8'h0c;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;
  localparam logic [7:0] BUFFER_OFFSET = 8'h14;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_OVERFLOW_BIT = 1;
  localparam int STATUS_CARRY_BIT = 2;
  localparam int STATUS_COUNT_LSB = 4;
  localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 13'h0000;

  typedef enum logic [1:0] {op_none, double_store_op, multiply_op,
    divide_op} op_t;
  typedef enum {ph_t1, ph_t2, ph_t3, ph_t4, ph_t5} phase_t;
  typedef enum {seq_idle, seq_store_ext, seq_store_acc, seq_fetch_tail,
    seq_mul_fetch, seq_mul_add, seq_mul_final, seq_div_fetch,
    seq_div_trial, seq_div_iter, seq_div_final} seq_state_t;

  typedef struct packed {
    logic [WORD_W-1:0] a;
    logic [WORD_W-1:0] b;
    logic carry_in;
  } adder_in_t;

  typedef struct packed {
    logic [WORD_W-1:0] sum;
    logic carry_out;
  } adder_out_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic read_strobe;
    logic memory_write_strobe;
    logic [WORD_W-1:0] write_data;
    logic data_valid;
  } mem_req_t;
endpackage : seq_pkg

// ===== hdl/phase_gen.sv
// Purpose: Five-phase memory cycle timing.
// Assumes: Runs freely from reset release.
// Notes: The phase shows T1 in the first cycle after reset.
module phase_gen (
  input wire logic pclk,
  input wire logic presetn,
  output seq_pkg::phase_t phase
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase <= seq_pkg::ph_t1;
    end
    else
    begin
      unique case (phase)
        seq_pkg::ph_t1: phase <= seq_pkg::ph_t2;
        seq_pkg::ph_t2: phase <= seq_pkg::ph_t3;
        seq_pkg::ph_t3: phase <= seq_pkg::ph_t4;
        seq_pkg::ph_t4: phase <= seq_pkg::ph_t5;
        seq_pkg::ph_t5: phase <= seq_pkg::ph_t1;
      endcase
    end
  end
endmodule : phase_gen

// ===== hdl/adder_unit.sv
// Purpose: Shared 24-bit adder with carry in and carry out.
// Assumes: Operand gating is done by the sequencer.
// Notes: Purely combinational.
module adder_unit (
  input seq_pkg::adder_in_t operands,
  output seq_pkg::adder_out_t result
);
  logic [seq_pkg::WORD_W:0] total;

  assign total = {1'b0, operands.a} + {1'b0, operands.b}
    + {{seq_pkg::WORD_W{1'b0}}, operands.carry_in};
  assign result.sum = total[seq_pkg::WORD_W-1:0];
  assign result.carry_out = total[seq_pkg::WORD_W];
endmodule : adder_unit

// ===== hdl/mul_div_sequencer.sv
// Purpose: Double-store, multiply and divide execution sequencer.
// Assumes: APB slave for software; one memory operation per memory cycle.
// Notes: Actions named for a phase take effect at the edge ending it.
//
// The address map and the APB register port were chosen for this implementation.
module mul_div_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [23:0] mem_read_data,
  output seq_pkg::mem_req_t mem_req
);
  seq_pkg::phase_t phase;
  seq_pkg::seq_state_t state;
  seq_pkg::op_t pending_op;
  seq_pkg::adder_in_t adder_in;
  seq_pkg::adder_out_t adder_out;
  logic [23:0] accumulator;
  logic [23:0] extension;
  logic [23:0] buffer;
  logic [12:0] operand_address;
  logic [4:0] iteration_counter;
  logic carry_flag;
  logic overflow_flag;
  logic extension_to_adder_a;
  logic accumulator_to_adder_a;
  logic buffer_to_adder_b;
  logic inverted_buffer_to_adder_b;
  logic busy;
  logic apb_write;
  logic apb_read;
  logic mapped;
  logic t1;
  logic t2;
  logic t4;
  logic t5;
  logic counter_zero;
  logic first_mul_iteration;
  logic store_state;
  logic fetch_state;
  logic [31:0] next_prdata;

  phase_gen timing (
    .pclk(pclk),
    .presetn(presetn),
    .phase(phase)
  );

  adder_unit adder (
    .operands(adder_in),
    .result(adder_out)
  );

  assign t1 = (phase == seq_pkg::ph_t1);
  assign t2 = (phase == seq_pkg::ph_t2);
  assign t4 = (phase == seq_pkg::ph_t4);
  assign t5 = (phase == seq_pkg::ph_t5);
  assign counter_zero = (iteration_counter == seq_pkg::COUNT_RESET);
  assign first_mul_iteration =
    (iteration_counter == seq_pkg::ITERATION_START);
  assign busy = (state != seq_pkg::seq_idle)
    || (pending_op != seq_pkg::op_none);
  assign store_state = (state == seq_pkg::seq_store_ext)
    || (state == seq_pkg::seq_store_acc);
  assign fetch_state = (state == seq_pkg::seq_mul_fetch)
    || (state == seq_pkg::seq_div_fetch);
  assign apb_write = psel && penable && pready && pwrite;
  assign apb_read = psel && penable && !pready && !pwrite;

  always_comb
  begin
    extension_to_adder_a = 1'b0;
    accumulator_to_adder_a = 1'b0;
    buffer_to_adder_b = 1'b0;
    inverted_buffer_to_adder_b = 1'b0;
    unique case (state)
      seq_pkg::seq_store_ext: extension_to_adder_a = 1'b1;
      seq_pkg::seq_store_acc: accumulator_to_adder_a = 1'b1;
      seq_pkg::seq_mul_add:
      begin
        accumulator_to_adder_a = 1'b1;
        buffer_to_adder_b = 1'b1;
      end
      seq_pkg::seq_div_trial, seq_pkg::seq_div_iter,
      seq_pkg::seq_div_final:
      begin
        accumulator_to_adder_a = 1'b1;
        inverted_buffer_to_adder_b = 1'b1;
      end
      seq_pkg::seq_idle, seq_pkg::seq_fetch_tail, seq_pkg::seq_mul_fetch,
      seq_pkg::seq_mul_final, seq_pkg::seq_div_fetch:
      begin
        extension_to_adder_a = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    adder_in.a = seq_pkg::WORD_RESET;
    if (extension_to_adder_a)
    begin
      adder_in.a = extension;
    end
    else if (accumulator_to_adder_a)
    begin
      adder_in.a = accumulator;
    end
    adder_in.b = seq_pkg::WORD_RESET;
    if (buffer_to_adder_b)
    begin
      adder_in.b = buffer;
    end
    else if (inverted_buffer_to_adder_b)
    begin
      adder_in.b = ~buffer;
    end
    adder_in.carry_in = inverted_buffer_to_adder_b;
  end

  // Sequencing: state moves at T5, or at T1 when the counter has run out.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= seq_pkg::seq_idle;
    end
    else
    begin
      unique case (state)
        seq_pkg::seq_idle:
        begin
          if (t5)
          begin
            unique case (pending_op)
              seq_pkg::double_store_op: state <= seq_pkg::seq_store_ext;
              seq_pkg::multiply_op: state <= seq_pkg::seq_mul_fetch;
              seq_pkg::divide_op: state <= seq_pkg::seq_div_fetch;
              seq_pkg::op_none: state <= seq_pkg::seq_idle;
            endcase
          end
        end
        seq_pkg::seq_store_ext:
        begin
          if (t5)
          begin
            state <= seq_pkg::seq_store_acc;
          end
        end
        seq_pkg::seq_store_acc:
        begin
          if (t5)
          begin
            state <= seq_pkg::seq_fetch_tail;
          end
        end
        seq_pkg::seq_fetch_tail, seq_pkg::seq_mul_final,
        seq_pkg::seq_div_final:
        begin
          if (t5)
          begin
            state <= seq_pkg::seq_idle;
          end
        end
        seq_pkg::seq_mul_fetch:
        begin
          if (t5)
          begin
            state <= seq_pkg::seq_mul_add;
          end
        end
        seq_pkg::seq_mul_add:
        begin
          if (t1 && counter_zero)
          begin
            state <= seq_pkg::seq_mul_final;
          end
        end
        seq_pkg::seq_div_fetch:
        begin
          if (t5)
          begin
            state <= seq_pkg::seq_div_trial;
          end
        end
        seq_pkg::seq_div_trial:
        begin
          if (t5)
          begin
            // An overflowing or zero-divisor trial skips to the fetch.
            if (adder_out.carry_out || (buffer == seq_pkg::WORD_RESET))
            begin
              state <= seq_pkg::seq_fetch_tail;
            end
            else
            begin
              state <= seq_pkg::seq_div_iter;
            end
          end
        end
        seq_pkg::seq_div_iter:
        begin
          if (t1 && counter_zero)
          begin
            state <= seq_pkg::seq_div_final;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pending_op <= seq_pkg::op_none;
    end
    else if (state == seq_pkg::seq_idle && t5 && busy)
    begin
      pending_op <= seq_pkg::op_none;
    end
    else if (apb_write && !busy && paddr == seq_pkg::CONTROL_OFFSET)
    begin
      pending_op <= seq_pkg::op_t'(pwdata[1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      operand_address <= seq_pkg::ADDR_RESET;
    end
    else if (apb_write && !busy && paddr == seq_pkg::OPERAND_OFFSET)
    begin
      operand_address <= pwdata[12:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      accumulator <= seq_pkg::WORD_RESET;
    end
    else if (apb_write && !busy && paddr == seq_pkg::ACCUMULATOR_OFFSET)
    begin
      accumulator <= pwdata[23:0];
    end
    else if (state == seq_pkg::seq_mul_fetch && t4)
    begin
      accumulator <= seq_pkg::WORD_RESET;
    end
    else if (state == seq_pkg::seq_mul_add && t1 && !first_mul_iteration)
    begin
      accumulator <= {1'b0, accumulator[23:1]};
    end
    else if (state == seq_pkg::seq_mul_add && t5 && extension[0])
    begin
      accumulator <= adder_out.sum;
    end
    else if (state == seq_pkg::seq_mul_final && t5)
    begin
      accumulator <= {1'b0, accumulator[23:1]};
    end
    else if (state == seq_pkg::seq_div_iter && t1)
    begin
      accumulator <= {accumulator[22:0], extension[23]};
    end
    else if ((state == seq_pkg::seq_div_iter
      || state == seq_pkg::seq_div_final) && t5 && adder_out.carry_out)
    begin
      accumulator <= adder_out.sum;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      extension <= seq_pkg::WORD_RESET;
    end
    else if (apb_write && !busy && paddr == seq_pkg::EXTENSION_OFFSET)
    begin
      extension <= pwdata[23:0];
    end
    else if (state == seq_pkg::seq_mul_fetch && t4)
    begin
      extension <= accumulator;
    end
    else if ((state == seq_pkg::seq_mul_add && t1 && !first_mul_iteration)
      || (state == seq_pkg::seq_mul_final && t5))
    begin
      extension <= {accumulator[0], extension[23:1]};
    end
    else if (state == seq_pkg::seq_div_iter && t1)
    begin
      extension <= {extension[22:0], carry_flag};
    end
    else if (state == seq_pkg::seq_div_final && t5)
    begin
      // The last quotient bit is the carry being stored at this edge.
      extension <= {extension[22:0], adder_out.carry_out};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      buffer <= seq_pkg::WORD_RESET;
    end
    else if (store_state && t4)
    begin
      buffer <= adder_out.sum;
    end
    else if (fetch_state && t4)
    begin
      buffer <= mem_read_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      iteration_counter <= seq_pkg::COUNT_RESET;
    end
    else if (fetch_state && t1)
    begin
      iteration_counter <= seq_pkg::ITERATION_START;
    end
    else if ((state == seq_pkg::seq_mul_add
      || state == seq_pkg::seq_div_iter) && t5 && !counter_zero)
    begin
      iteration_counter <= iteration_counter - 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      carry_flag <= 1'b0;
    end
    else if ((state == seq_pkg::seq_div_trial
      || state == seq_pkg::seq_div_iter
      || state == seq_pkg::seq_div_final) && t5)
    begin
      carry_flag <= adder_out.carry_out;
    end
  end

  // The trial load wins over a software clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      overflow_flag <= 1'b0;
    end
    else if (state == seq_pkg::seq_div_trial && t5)
    begin
      overflow_flag <= adder_out.carry_out
        || (buffer == seq_pkg::WORD_RESET);
    end
    else if (apb_write && paddr == seq_pkg::STATUS_OFFSET
      && pwdata[seq_pkg::STATUS_OVERFLOW_BIT])
    begin
      overflow_flag <= 1'b0;
    end
  end

  // Memory requests are registered one phase early so that they stand
  // at the pins during the named phase.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_req <= '0;
    end
    else if (t2 && store_state)
    begin
      mem_req.addr <= operand_address
        | {12'h000, state == seq_pkg::seq_store_ext};
      mem_req.memory_write_strobe <= 1'b1;
    end
    else if (t2 && fetch_state)
    begin
      mem_req.addr <= operand_address;
      mem_req.read_strobe <= 1'b1;
    end
    else if (t4 && store_state)
    begin
      mem_req.write_data <= adder_out.sum;
      mem_req.data_valid <= 1'b1;
    end
    else if (t4)
    begin
      mem_req.read_strobe <= 1'b0;
    end
    else if (t5)
    begin
      mem_req.memory_write_strobe <= 1'b0;
      mem_req.data_valid <= 1'b0;
    end
  end

  always_comb
  begin
    next_prdata = 32'h00000000;
    mapped = 1'b1;
    unique case (paddr)
      seq_pkg::CONTROL_OFFSET: next_prdata = {30'h0, pending_op};
      seq_pkg::OPERAND_OFFSET: next_prdata = {19'h0, operand_address};
      seq_pkg::ACCUMULATOR_OFFSET: next_prdata = {8'h00, accumulator};
      seq_pkg::EXTENSION_OFFSET: next_prdata = {8'h00, extension};
      seq_pkg::BUFFER_OFFSET: next_prdata = {8'h00, buffer};
      seq_pkg::STATUS_OFFSET:
      begin
        next_prdata[seq_pkg::STATUS_BUSY_BIT] = busy;
        next_prdata[seq_pkg::STATUS_OVERFLOW_BIT] = overflow_flag;
        next_prdata[seq_pkg::STATUS_CARRY_BIT] = carry_flag;
        next_prdata[seq_pkg::STATUS_COUNT_LSB +: 5] = iteration_counter;
      end
      default: mapped = 1'b0;
    endcase
  end

  // One wait state keeps read data and error straight from flip-flops.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (apb_read)
      begin
        prdata <= next_prdata;
      end
    end
  end
endmodule : mul_div_sequencer

// ===== dv/seq_props.sv
// Purpose: Port checker for the sequencer, bound to its top module.
// Assumes: Only the top module's ports are visible here.
// Notes: Memory request fields are watched directly inside the struct.
module seq_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [23:0] mem_read_data,
  input seq_pkg::mem_req_t mem_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_store_pair;
    $rose(mem_req.memory_write_strobe) && mem_req.addr[0] |-> ##5
      ($rose(mem_req.memory_write_strobe)
      && mem_req.addr == ($past(mem_req.addr, 5) & 13'h1ffe));
  endproperty
  a_store_pair: assert property (p_store_pair)
    else $error("second store word is not at the even address");
  property p_even_after_odd;
    $rose(mem_req.memory_write_strobe) && !mem_req.addr[0] |->
      $past(mem_req.memory_write_strobe, 5) && $past(mem_req.addr[0], 5);
  endproperty
  a_even_after_odd: assert property (p_even_after_odd)
    else $error("even store word without an odd word before it");
  property p_strobe_span;
    $rose(mem_req.memory_write_strobe) |->
      mem_req.memory_write_strobe [*3] ##1 !mem_req.memory_write_strobe;
  endproperty
  a_strobe_span: assert property (p_strobe_span)
    else $error("write strobe does not span three phases");
  property p_data_t5;
    $rose(mem_req.memory_write_strobe) |->
      !mem_req.data_valid [*2] ##1 mem_req.data_valid ##1 !mem_req.data_valid;
  endproperty
  a_data_t5: assert property (p_data_t5)
    else $error("store data not presented in the fifth phase only");
  property p_valid_store;
    mem_req.data_valid |-> mem_req.memory_write_strobe;
  endproperty
  a_valid_store: assert property (p_valid_store)
    else $error("store data offered outside a write");
  property p_read_span;
    $rose(mem_req.read_strobe) |->
      mem_req.read_strobe [*2] ##1 !mem_req.read_strobe;
  endproperty
  a_read_span: assert property (p_read_span)
    else $error("read strobe does not span two phases");
  property p_exclusive;
    !(mem_req.read_strobe && mem_req.memory_write_strobe);
  endproperty
  a_exclusive: assert property (p_exclusive)
    else $error("read and write strobes overlap");
  property p_ready_wait;
    psel && penable && !$past(penable) |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("bus answer not in the second access cycle");
  property p_err_zero;
    pready && pslverr && !pwrite |-> prdata == 32'h00000000;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("refused read returns nonzero data");
  c_store: cover property ($rose(mem_req.memory_write_strobe));
  c_read: cover property ($rose(mem_req.read_strobe));
  c_err: cover property (pready && pslverr);
endmodule : seq_props

bind mul_div_sequencer seq_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mem_read_data(mem_read_data), .mem_req(mem_req));

// ===== dv/core_memory.sv
// Purpose: Behavioural core memory on the far side of the sequencer.
// Assumes: The bench preloads operand words by hierarchical access.
// Notes: Outside a read the data lines show the inverse of the last word.
module core_memory (
  input wire logic pclk,
  input seq_pkg::mem_req_t mem_req,
  output logic [23:0] mem_read_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] words [0:8191];
  logic [23:0] last_word = 24'h000000;
  always @(posedge pclk)
  begin
    if (mem_req.memory_write_strobe && mem_req.data_valid)
      words[mem_req.addr] <= mem_req.write_data;
    if (mem_req.read_strobe)
      last_word <= words[mem_req.addr];
  end
  // A stale word on idle lines could hide a sampling slip in the design.
  assign mem_read_data = mem_req.read_strobe ? words[mem_req.addr] :
    ~last_word;
endmodule : core_memory

// ===== dv/testbench.sv
// Purpose: Self-checking bench for the sequencer.
// Assumes: APB master here, behavioural core memory on the far side.
// Notes: Expected results come from plain arithmetic on the operands.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [23:0] mem_read_data;
  seq_pkg::mem_req_t mem_req;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  int rs_cyc = 0;
  int n_writes = 0;
  logic rs_prev = 1'b0;

  always #20 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    rs_prev <= mem_req.read_strobe;
    if (mem_req.read_strobe && !rs_prev)
      rs_cyc <= cyc;
    if (mem_req.data_valid && mem_req.memory_write_strobe)
      n_writes <= n_writes + 1;
  end

  mul_div_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_read_data(mem_read_data), .mem_req(mem_req));
  core_memory far_mem (.pclk(pclk), .mem_req(mem_req),
    .mem_read_data(mem_read_data));

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic hang(input string w);
    mismatches++;
    $display("[ERR] %0t timeout: %s", $time, w);
    complete_run();
  endtask : hang

  task automatic chk(input logic [47:0] got, input logic [47:0] exp,
    input string w);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s: got %h expected %h", $time, w, got, exp);
    end
  endtask : chk

  task automatic lat_ok(input int lat, input int n, input string w);
    chk(48'(lat >= 5 * n - 3 && lat <= 5 * n + 4), 48'h1, w);
  endtask : lat_ok

  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 16)
      hang("bus answer");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
  endtask : rd

  // Busy is first awaited high; the pending operation already raises it before dispatch at the end of T5.
  task automatic wait_idle(input bit poke, output int lat);
    logic [31:0] s;
    bit seen;
    int k;
    seen = 0;
    for (k = 0; k < 90; k++)
    begin
      rd(seq_pkg::STATUS_OFFSET, s);
      if (s[seq_pkg::STATUS_BUSY_BIT] === 1'b1 && !seen && poke)
      begin
        wr(seq_pkg::ACCUMULATOR_OFFSET, 32'h00000001);
        wr(seq_pkg::CONTROL_OFFSET, 32'h00000003);
      end
      if (s[seq_pkg::STATUS_BUSY_BIT] === 1'b1)
        seen = 1;
      else if (seen)
        break;
    end
    lat = cyc - rs_cyc;
    if (k == 90)
      hang("sequencer busy");
  endtask : wait_idle

  task automatic run_op(input logic [23:0] a, e, input logic [12:0] adr,
    input logic [31:0] op, input bit poke, output int lat);
    wr(seq_pkg::ACCUMULATOR_OFFSET, {8'h00, a});
    wr(seq_pkg::EXTENSION_OFFSET, {8'h00, e});
    wr(seq_pkg::OPERAND_OFFSET, {19'h00000, adr});
    wr(seq_pkg::CONTROL_OFFSET, op);
    wait_idle(poke, lat);
  endtask : run_op

  task automatic test_regs();
    logic [31:0] d;
    logic e;
    logic [7:0] offs [6] = '{seq_pkg::CONTROL_OFFSET,
      seq_pkg::OPERAND_OFFSET, seq_pkg::ACCUMULATOR_OFFSET,
      seq_pkg::EXTENSION_OFFSET, seq_pkg::STATUS_OFFSET,
      seq_pkg::BUFFER_OFFSET};
    foreach (offs[i])
    begin
      rd(offs[i], d);
      chk(48'(d), 48'h0, "reset value");
    end
    apb(1'b0, 8'h18, 32'h00000000, d, e);
    chk(48'({e, d}), 48'h100000000, "unmapped read");
    apb(1'b1, 8'h40, 32'h00000001, d, e);
    chk(48'(e), 48'h1, "unmapped write");
    wr(seq_pkg::BUFFER_OFFSET, 32'h00abcdef);
    rd(seq_pkg::BUFFER_OFFSET, d);
    chk(48'(d), 48'h0, "buffer write");
    wr(seq_pkg::ACCUMULATOR_OFFSET, 32'hff123456);
    rd(seq_pkg::ACCUMULATOR_OFFSET, d);
    chk(48'(d), 48'h123456, "upper bits");
    $display("test_regs done");
  endtask : test_regs

  task automatic test_store();
    logic [12:0] adr [2] = '{13'h0100, 13'h1ffe};
    int n0;
    int lat;
    foreach (adr[i])
    begin
      far_mem.words[adr[i]] = 24'h000000;
      far_mem.words[adr[i] | 13'h0001] = 24'h000000;
      n0 = n_writes;
      run_op(24'h123456 + 24'(i), 24'h654321, adr[i], 32'h1, 0, lat);
      chk(48'(far_mem.words[adr[i] | 13'h0001]), 48'h654321, "odd word");
      chk(48'(far_mem.words[adr[i]]), 48'h123456 + 48'(i), "even word");
      chk(48'(n_writes - n0), 48'h2, "store count");
    end
    $display("test_store done");
  endtask : test_store

  task automatic test_mul();
    logic [23:0] ca [3] = '{24'h000005, 24'h7fffff, 24'h2aaaaa};
    logic [23:0] cb [3] = '{24'h000003, 24'h7fffff, 24'h555555};
    logic [47:0] p;
    logic [31:0] d;
    int lat;
    foreach (ca[i])
    begin
      p = 48'(ca[i]) * 48'(cb[i]);
      far_mem.words[13'h0200 + 13'(i)] = cb[i];
      run_op(ca[i], 24'h0f0f0f, 13'h0200 + 13'(i), 32'h2, i == 0, lat);
      rd(seq_pkg::ACCUMULATOR_OFFSET, d);
      chk(48'(d), 48'(p[47:24]), "product high");
      rd(seq_pkg::EXTENSION_OFFSET, d);
      chk(48'(d), 48'(p[23:0]), "product low");
      rd(seq_pkg::BUFFER_OFFSET, d);
      chk(48'(d), 48'(cb[i]), "multiplicand");
      lat_ok(lat, 25, "multiply length");
    end
    $display("test_mul done");
  endtask : test_mul

  task automatic test_div();
    logic [23:0] ca [5] = '{24'h000001, 24'h000000, 24'h3fffff,
      24'h000005, 24'h000000};
    logic [23:0] ce [5] = '{24'h000000, 24'h000007, 24'hffffff,
      24'h000000, 24'h000010};
    logic [23:0] cd [5] = '{24'h000003, 24'h000002, 24'h7fffff,
      24'h000005, 24'h000000};
    logic [47:0] n;
    logic [47:0] q;
    logic [31:0] s;
    int lat;
    foreach (ca[i])
    begin
      n = {ca[i], ce[i]};
      far_mem.words[13'h0300 + 13'(i)] = cd[i];
      run_op(ca[i], ce[i], 13'h0300 + 13'(i), 32'h3, 0, lat);
      rd(seq_pkg::BUFFER_OFFSET, s);
      chk(48'(s), 48'(cd[i]), "divisor");
      rd(seq_pkg::STATUS_OFFSET, s);
      chk(48'(s[seq_pkg::STATUS_OVERFLOW_BIT]), 48'(i >= 3), "overflow");
      if (i >= 3)
      begin
        lat_ok(lat, 3, "aborted divide length");
        wr(seq_pkg::STATUS_OFFSET, 32'h00000002);
        rd(seq_pkg::STATUS_OFFSET, s);
        chk(48'(s[seq_pkg::STATUS_OVERFLOW_BIT]), 48'h0, "overflow clear");
      end
      else
      begin
        lat_ok(lat, 26, "divide length");
        q = n / 48'(cd[i]);
        chk(48'(s[seq_pkg::STATUS_CARRY_BIT]), 48'(q[0]), "carry");
        rd(seq_pkg::EXTENSION_OFFSET, s);
        chk(48'(s), n / 48'(cd[i]), "quotient");
        rd(seq_pkg::ACCUMULATOR_OFFSET, s);
        chk(48'(s), n % 48'(cd[i]), "remainder");
      end
    end
    $display("test_div done");
  endtask : test_div

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    test_regs();
    test_store();
    test_mul();
    test_div();
    complete_run();
  end
endmodule : testbench
